/* File: sadc_ctrl.sv */
// serial control and result port of a sampling 8-bit converter
// assumes the host clocks the link; analog front end answers through the buffer
module sadc_ctrl
  import sadc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // variant strap, static while running
  input wire logic two_channel_in,
  // serial pins
  input wire logic chip_select_shutdown_in,
  input wire logic shift_clk_in,
  input wire logic serial_config_in,
  output logic serial_result_out,
  output logic serial_result_oe_out,
  // analog front end
  output logic power_on_out,
  output logic sampling_out,
  output logic [1:0] mux_sel_out,
  output logic conv_start_out,
  input wire logic result_valid_in,
  input wire logic [SADC_RES_W-1:0] result_data_in,
  output logic result_ready_out
);
  // ----------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] pins_s;
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic sclk_prev_q;
  logic sel;
  logic rise;
  logic fall;

  sadc_sync #(
    .W(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in({chip_select_shutdown_in, shift_clk_in, serial_config_in}),
    .sync_out(pins_s)
  );

  assign cs_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];
  assign sel = !cs_s; // [RL1]
  assign rise = sclk_s && !sclk_prev_q; // [RL4]
  assign fall = !sclk_s && sclk_prev_q; // [RL4]

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // ----------------------------------------
  // result buffer
  // ----------------------------------------
  logic buf_valid;
  logic [SADC_RES_W-1:0] buf_data;
  logic buf_pop;

  // flushed while deselected so a late word never leaks into the next cycle
  sadc_buf #(
    .W(SADC_RES_W),
    .DEPTH(SADC_BUF_DEPTH)
  ) u_buf (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .flush_in(!sel),
    .in_valid_in(result_valid_in),
    .in_data_in(result_data_in),
    .in_ready_out(result_ready_out),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(buf_pop)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  sadc_state_t state_q;
  logic [1:0] cfg_cnt_q;
  logic [1:0] smpl_cnt_q;
  logic [4:0] bit_cnt_q;
  logic [2:0] cfg_q;
  logic [SADC_RES_W-1:0] word_q;
  logic [SADC_RES_W-1:0] cur_word;
  logic msb_first_only;
  logic smpl_done;
  logic shift_end;

  // single-input variant always sends both orders
  assign msb_first_only = two_channel_in ? cfg_q[SADC_CFG_MSB_FIRST_ONLY] : 1'b0; // [RL16]
  assign smpl_done = (state_q == SADC_ST_SMPL) && fall && (smpl_cnt_q == SADC_SMPL_FALLS - 2'h1);
  assign shift_end = msb_first_only ? (bit_cnt_q == 5'(SADC_RES_W - 1))
                          : (bit_cnt_q == 5'(2 * SADC_RES_W - 1)); // [RL19]
  // an empty buffer at msb time yields zeros; the front end must be quicker than one shift clock
  assign cur_word = (bit_cnt_q == 5'h00) ? (buf_valid ? buf_data : '0) : word_q;
  assign buf_pop = (state_q == SADC_ST_SHIFT) && fall && (bit_cnt_q == 5'h00);

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || !sel) begin
      state_q <= SADC_ST_IDLE; // [RL2]
    end else begin
      unique case (state_q)
        SADC_ST_IDLE: begin
          if (rise && (din_s || !two_channel_in)) begin
            // zeros before the start bit leave the state alone [RL7]
            state_q <= two_channel_in ? SADC_ST_CFG : SADC_ST_SMPL; // [RL6] [RL15]
          end
        end
        SADC_ST_CFG: begin
          if (rise && (cfg_cnt_q == 2'(SADC_CFG_BITS - 1))) begin
            state_q <= SADC_ST_SMPL;
          end
        end
        SADC_ST_SMPL: begin
          if (smpl_done) begin
            state_q <= SADC_ST_SHIFT; // [RL17]
          end
        end
        SADC_ST_SHIFT: begin
          if (fall && shift_end) begin
            state_q <= SADC_ST_FILL;
          end
        end
        SADC_ST_FILL: begin
          state_q <= SADC_ST_FILL; // [RL8]
        end
      endcase
    end
  end

  // ----------------------------------------
  // configuration capture
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      cfg_q <= SADC_CFG_RST;
      cfg_cnt_q <= 2'h0;
    end else if (state_q == SADC_ST_IDLE) begin
      cfg_cnt_q <= 2'h0;
    end else if ((state_q == SADC_ST_CFG) && rise) begin
      // shifted in single, polarity, msb-only [RL20] [RL5]
      cfg_q <= {cfg_q[1:0], din_s};
      cfg_cnt_q <= cfg_cnt_q + 2'h1;
    end
  end

  // ----------------------------------------
  // edge counters
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || state_q == SADC_ST_IDLE) begin
      smpl_cnt_q <= 2'h0;
      bit_cnt_q <= 5'h00;
    end else begin
      if ((state_q == SADC_ST_SMPL) && fall) begin
        smpl_cnt_q <= smpl_cnt_q + 2'h1;
      end
      if ((state_q == SADC_ST_SHIFT) && fall) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      word_q <= '0;
    end else if (buf_pop) begin
      word_q <= cur_word;
    end
  end

  // ----------------------------------------
  // result pin
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || !sel) begin
      serial_result_out <= 1'b0;
      serial_result_oe_out <= 1'b0; // [RL21]
    end else if (fall) begin // [RL18]
      if (smpl_done) begin
        serial_result_out <= 1'b0;
        serial_result_oe_out <= 1'b1; // [RL3]
      end else if (state_q == SADC_ST_SHIFT) begin
        if (bit_cnt_q < 5'(SADC_RES_W)) begin
          serial_result_out <= cur_word[SADC_RES_W - 1 - int'(bit_cnt_q)]; // [RL12] [RL14]
        end else begin
          serial_result_out <= word_q[int'(bit_cnt_q) - SADC_RES_W]; // [RL14] [RL16]
        end
      end else if (state_q == SADC_ST_FILL) begin
        serial_result_out <= 1'b0; // [RL13]
      end
    end
  end

  // ----------------------------------------
  // front end controls
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      power_on_out <= 1'b0;
      sampling_out <= 1'b0;
      conv_start_out <= 1'b0;
      mux_sel_out <= SADC_MUX_A_MINUS_B;
    end else begin
      power_on_out <= sel; // [RL1] [RL2]
      sampling_out <= sel && (state_q == SADC_ST_SMPL) && !smpl_done; // [RL17]
      conv_start_out <= sel && smpl_done;
      // ground-referenced codes carry single_ended_select high [RL9] [RL10] [RL11]
      mux_sel_out <= two_channel_in ? cfg_q[SADC_CFG_SGL:SADC_CFG_ODD] : SADC_MUX_A_MINUS_B; // [RL15]
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  AST_OE_OFF_DESEL: assert property (!sel |=> !serial_result_oe_out) // [RL21]
    else $error("result driven while deselected");
  AST_POWER_FOLLOWS_SEL: assert property (sel |=> power_on_out ##0 $past(sel) == power_on_out) // [RL1]
    else $error("power does not follow select");
  AST_ABORT_TO_IDLE: assert property (!sel |=> state_q == SADC_ST_IDLE) // [RL2]
    else $error("cycle not aborted on deselect");
  AST_CHANGE_AFTER_FALL: assert property ($changed(serial_result_out) |-> $past(fall) || $past(!sel)) // [RL18]
    else $error("result changed away from falling edge");
  AST_ZEROS_IGNORED: assert property (sel && state_q == SADC_ST_IDLE && two_channel_in && rise
    && !din_s |=> state_q == SADC_ST_IDLE) // [RL7]
    else $error("leading zero taken as start");
  AST_START_BIT: assert property (sel && state_q == SADC_ST_IDLE && two_channel_in && rise
    && din_s |=> state_q == SADC_ST_CFG) // [RL6]
    else $error("start bit not taken");
  AST_CFG_FROZEN: assert property (state_q inside {SADC_ST_SMPL, SADC_ST_SHIFT, SADC_ST_FILL}
    |=> $stable(cfg_q)) // [RL8]
    else $error("config changed after capture");
  AST_SAMPLE_TO_START: assert property (sel && smpl_done |=> conv_start_out ##1 !conv_start_out) // [RL17]
    else $error("conversion did not start after sampling");
  AST_MUX_DECODE: assert property (conv_start_out |-> mux_sel_out == (two_channel_in
    ? cfg_q[SADC_CFG_SGL:SADC_CFG_ODD] : SADC_MUX_A_MINUS_B)) // [RL10]
    else $error("mux setting wrong at conversion start");
  AST_MSB_FIRST: assert property (sel && buf_pop ##1 sel |-> serial_result_out == word_q[SADC_RES_W-1]) // [RL12]
    else $error("first result bit is not msb");
  AST_FILL_ZERO: assert property (sel && state_q == SADC_ST_FILL && fall ##1 sel
    |-> !serial_result_out) // [RL13]
    else $error("fill bit not zero");
  AST_OE_AFTER_SAMPLE: assert property (sampling_out |-> !serial_result_oe_out) // [RL17]
    else $error("result driven during sampling");
  AST_NULL_BIT_LOW: assert property ($rose(serial_result_oe_out) // [RL18]
    |-> !serial_result_out)
    else $error("first driven bit not low");
  AST_DESEL_QUIET: assert property (!sel |=> !power_on_out && !sampling_out) // [RL2]
    else $error("front end active while deselected");
  AST_DESEL_NO_START: assert property (!sel |=> !conv_start_out) // [RL2]
    else $error("conversion started while deselected");
  AST_FLUSH_READY: assert property (!sel |=> result_ready_out) // [RL2]
    else $error("buffer not flushed while deselected");
  AST_CFG_COUNT: assert property (state_q == SADC_ST_CFG // [RL8]
    |-> cfg_cnt_q < 2'(SADC_CFG_BITS))
    else $error("config word longer than three bits");
  AST_SHIFT_BOUND: assert property (state_q == SADC_ST_SHIFT // [RL19]
    |-> bit_cnt_q < 5'(2 * SADC_RES_W))
    else $error("result longer than two words");
  AST_MSB_FIRST_ONLY_STOPS: assert property (sel && state_q == SADC_ST_SHIFT && fall && msb_first_only // [RL13]
    && bit_cnt_q == 5'(SADC_RES_W - 1) |=> state_q == SADC_ST_FILL)
    else $error("msb-only result not followed by fill");
  AST_LSB_FOLLOWS: assert property (sel && state_q == SADC_ST_SHIFT && fall && !msb_first_only // [RL14]
    && bit_cnt_q == 5'(SADC_RES_W - 1) |=> state_q == SADC_ST_SHIFT)
    else $error("lsb-first copy missing");
  AST_SINGLE_NO_CFG: assert property (!two_channel_in |-> state_q != SADC_ST_CFG) // [RL15]
    else $error("single-input variant took a config word");
  AST_SINGLE_MUX: assert property (!two_channel_in && conv_start_out // [RL15]
    |-> mux_sel_out == SADC_MUX_A_MINUS_B)
    else $error("single-input variant not on the fixed pair");

  COV_TWO_CH_MSB_FIRST_ONLY: cover property (state_q == SADC_ST_SHIFT && two_channel_in && msb_first_only
    ##1 state_q == SADC_ST_FILL);
  COV_BOTH_ORDERS: cover property (state_q == SADC_ST_SHIFT && !msb_first_only ##1 state_q == SADC_ST_FILL);
  COV_ABORT_MID: cover property (state_q == SADC_ST_SHIFT ##1 state_q == SADC_ST_IDLE);
  COV_SINGLE_PAIR: cover property (!two_channel_in && conv_start_out);
  // a third word must be held off by ready, never dropped
  COV_BUF_FULL: cover property (result_valid_in && !result_ready_out);
endmodule

/* File: sadc_pkg.sv */
// shared constants and types for the serial converter control port
// assumes one system clock; all pins are sampled by that clock
//
// Behaviour
// (RL1) selected only while chip select held low
// (RL2) chip select high powers down, aborts cycle
// (RL3) result leaves serially on the result line
// (RL4) host supplies shift clock timing all bits
// (RL5) two-channel variant samples config on rising edges
// (RL6) first one after select is start bit
// (RL7) zeros before the start bit are discarded
// (RL8) config input ignored until next select cycle
// (RL9) config bits after start select the multiplexer
// (RL10) mux decode: single/polarity pick input pairing
// (RL11) single-ended inputs measured against ground
// (RL12) msb-only set: result sent msb first
// (RL13) msb-only set: zeros follow while selected
// (RL14) msb-only clear: msb first then lsb first
// (RL15) single-input variant: fixed differential pair, no config
// (RL16) single-input variant: msb first then lsb first
// (RL17) sample for one and half shift clocks
// (RL18) result changes only after shift clock falls
// (RL19) result is eight bits wide
// (RL20) config order: single, polarity, msb-only
// (RL21) result line undriven while deselected
package sadc_pkg;
  // ----------------------------------------
  // widths and field positions
  // ----------------------------------------
  localparam int SADC_RES_W = 8;
  localparam int SADC_CFG_BITS = 3;
  localparam int SADC_CFG_SGL = 2;
  localparam int SADC_CFG_ODD = 1;
  localparam int SADC_CFG_MSB_FIRST_ONLY = 0;
  localparam logic [2:0] SADC_CFG_RST = 3'h0;
  // ----------------------------------------
  // multiplexer codes {single_ended_select, channel_polarity_select}
  // ----------------------------------------
  localparam logic [1:0] SADC_MUX_A_GND = 2'h2;
  localparam logic [1:0] SADC_MUX_B_GND = 2'h3;
  localparam logic [1:0] SADC_MUX_A_MINUS_B = 2'h0;
  localparam logic [1:0] SADC_MUX_B_MINUS_A = 2'h1;
  // ----------------------------------------
  // timing in shift clock edges and buffer depth
  // ----------------------------------------
  // 1.5 cycles from the last config rise end at the second fall
  localparam logic [1:0] SADC_SMPL_FALLS = 2'h2;
  localparam int SADC_BUF_DEPTH = 2;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    SADC_ST_IDLE = 5'h01,
    SADC_ST_CFG = 5'h02,
    SADC_ST_SMPL = 5'h04,
    SADC_ST_SHIFT = 5'h08,
    SADC_ST_FILL = 5'h10
  } sadc_state_t;
endpackage

/* File: sadc_sync.sv */
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk_sys_in
module sadc_sync
  import sadc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* File: sadc_buf.sv */
// small result buffer with valid/ready on both sides
// assumes producer and consumer share clk_sys_in
module sadc_buf
  import sadc_pkg::*;
#(
  parameter int W = SADC_RES_W,
  parameter int DEPTH = SADC_BUF_DEPTH
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && (cnt_q != '0);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_ptr_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // ready is a flop so back-pressure never depends on the consumer combinationally
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || flush_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      in_ready_out <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
      end
      cnt_q <= cnt_d;
      in_ready_out <= (cnt_d < CW'(DEPTH));
    end
  end
endmodule

/* File: sadc_host_model.sv */
// host-side model: drives select, shift clock and config, reads the result pin
// assumes the result pin floats while its enable is low; a stale level is inverted
module sadc_host_model (
  // result pin
  input wire logic serial_result_in,
  input wire logic serial_result_oe_in,
  // host pins
  output logic chip_select_shutdown_out,
  output logic shift_clk_out,
  output logic serial_config_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // pin resolution
  // ----------------------------------------
  logic last_q = 1'b0;
  logic line;
  always @(*) if (serial_result_oe_in) last_q = serial_result_in;
  // undriven pin must not look like the last bit
  assign line = serial_result_oe_in ? serial_result_in : ~last_q;
  initial begin
    chip_select_shutdown_out = 1'b1;
    shift_clk_out = 1'b0;
    serial_config_out = 1'b0;
  end
  // ----------------------------------------
  // one select cycle of n shift clocks
  // ----------------------------------------
  // clock stands still outside frames
  task automatic frame(input logic [31:0] din, input int n, output logic [31:0] got);
    got = '0;
    chip_select_shutdown_out = 1'b0;
    #60;
    for (int i = 0; i < n; i++) begin
      serial_config_out = din[i];
      #24;
      shift_clk_out = 1'b1;
      got[i] = line;
      #24;
      shift_clk_out = 1'b0;
    end
    #24;
    chip_select_shutdown_out = 1'b1;
    serial_config_out = 1'b0;
    #100;
  endtask
endmodule

/* File: sadc_ctrl_tb.sv */
// self-checking bench for the converter control port
// assumes the host model clocks the link; this bench plays the front end
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %b expected %b", $time, a, b); end end
module sadc_ctrl_tb
  import sadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic two_channel_in = 1'b0;
  logic rvalid = 1'b0;
  logic [SADC_RES_W-1:0] rdata = 8'h00;
  logic refused = 1'b0;
  logic took = 1'b0;
  logic cs, sck, sdi, sdo, sdo_oe, power_on, sampling, conv_start, rready;
  logic [1:0] mux_sel, seen_mux, code, exp_mux;
  logic [7:0] word = 8'h00;
  logic [31:0] din, got;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int pend = 0;
  int n_push = 1;
  int smpl_run = 0;
  int smpl_len = 0;
  // 1.5 shift clocks of 48 ns in 4 ns cycles; pin sync may shorten the seen window
  localparam int SMPL_CYC = 18;
  always #2 clk_sys_in = ~clk_sys_in;
  sadc_ctrl i_sadc_ctrl (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .two_channel_in(two_channel_in), .chip_select_shutdown_in(cs), .shift_clk_in(sck),
    .serial_config_in(sdi), .serial_result_out(sdo), .serial_result_oe_out(sdo_oe),
    .power_on_out(power_on), .sampling_out(sampling), .mux_sel_out(mux_sel),
    .conv_start_out(conv_start), .result_valid_in(rvalid), .result_data_in(rdata),
    .result_ready_out(rready));
  sadc_host_model i_sadc_host_model (.serial_result_in(sdo), .serial_result_oe_in(sdo_oe),
    .chip_select_shutdown_out(cs), .shift_clk_out(sck), .serial_config_out(sdi));
  // ----------------------------------------
  // front end: n_push words per conversion
  // ----------------------------------------
  always @(posedge clk_sys_in) begin
    took <= rvalid && rready;
    if (rvalid && !rready) refused <= 1'b1;
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // data holds until taken, so a stalled word is never lost
  always @(negedge clk_sys_in) begin
    if (took) pend--;
    if (sampling === 1'b1) smpl_run++;
    else if (smpl_run != 0) begin
      smpl_len = smpl_run;
      smpl_run = 0;
    end
    if (conv_start === 1'b1) begin
      pend = n_push;
      seen_mux = mux_sel;
    end
    rvalid <= (pend > 0);
    rdata <= word + 8'(n_push - pend);
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // r0 is the rise that carries the last config bit, or the start rise on the single pair
  task automatic chk_frame(input logic [31:0] g, input int r0, input logic lsb);
    `CHK((smpl_len >= SMPL_CYC - 2) && (smpl_len <= SMPL_CYC), 1'b1);
    `CHK(g[r0+2], 1'b0);
    for (int k = 0; k < 8; k++) begin
      `CHK(g[r0+3+k], word[7-k]);
      `CHK(g[r0+11+k], lsb & word[k]);
    end
    `CHK(g[r0+19], 1'b0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    `CHK(sdo_oe, 1'b0);
    `CHK(power_on, 1'b0);
    // single pair: config pin held high must not matter
    word = 8'hC1;
    i_sadc_host_model.frame(32'hFFFF_FFFF, 22, got);
    chk_frame(got, 0, 1'b1);
    @(negedge clk_sys_in);
    two_channel_in = 1'b1;
    for (int m = 0; m < 4; m++) begin
      code = 2'(m);
      word = 8'h96 ^ 8'(m * 17);
      exp_mux = code[1] ? (code[0] ? SADC_MUX_B_GND : SADC_MUX_A_GND)
                        : (code[0] ? SADC_MUX_B_MINUS_A : SADC_MUX_A_MINUS_B);
      din = {26'h0, 1'b1, code[0], code[1], 1'b1, 2'h0};
      i_sadc_host_model.frame(din, 28, got);
      `CHK(seen_mux, exp_mux);
      chk_frame(got, 5, 1'b0);
    end
    // trailing ones after the word must be ignored
    word = 8'h4D;
    din = {26'h3FF_FFFF, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0};
    i_sadc_host_model.frame(din, 28, got);
    chk_frame(got, 5, 1'b1);
    // deselect in mid-shift
    word = 8'h33;
    i_sadc_host_model.frame(din, 10, got);
    `CHK(sdo_oe, 1'b0);
    `CHK(power_on, 1'b0);
    // three words offered: buffer fills and stalls the source
    n_push = 3;
    word = 8'h5E;
    din = {26'h0, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0};
    i_sadc_host_model.frame(din, 28, got);
    `CHK(refused, 1'b1);
    chk_frame(got, 5, 1'b0);
    `CHK(rready, 1'b1);
    // no answer from the front end gives an all-zero word
    n_push = 0;
    word = 8'h00;
    i_sadc_host_model.frame(din, 28, got);
    chk_frame(got, 5, 1'b0);
    stop_test();
  end
endmodule
